/* File: hdl/eba_pkg.sv */
// constants for the byte-wide eeprom access control block
package eba_pkg;

  // ****************************************************
  // register offsets (data space) and short i/o displacement
  // ****************************************************
  localparam logic [7:0] CTRL_OFS      = 8'h3F;
  localparam logic [7:0] DATA_OFS      = 8'h40;
  localparam logic [7:0] ADDR_LO_OFS   = 8'h41;
  localparam logic [7:0] ADDR_HI_STEP  = 8'h01;
  localparam logic [7:0] IO_SHORT_DISP = 8'h20;

  // ****************************************************
  // control register fields
  // ****************************************************
  localparam int CTRL_RSTB_BIT = 0;
  localparam int CTRL_WSTB_BIT = 1;
  localparam int CTRL_MWE_BIT  = 2;
  localparam int CTRL_RIE_BIT  = 3;
  localparam int CTRL_PM_LSB   = 4;
  localparam int CTRL_PM_MSB   = 5;

  // ****************************************************
  // field widths and reset values
  // ****************************************************
  localparam int          ADDR_W      = 10;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [9:0]  ADDR_RST    = 10'h000;
  localparam logic [1:0]  MODE_RST    = 2'h0;

  // programming modes
  localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
  localparam logic [1:0] MODE_RESERVED    = 2'h3;

  // ****************************************************
  // cycle counts
  // ****************************************************
  localparam logic [2:0] MWE_CYCLES         = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;
  localparam int         WRITE_RC_CYCLES    = 26368;
  localparam int         RC_CNT_W           = 15;

  typedef enum logic {EBA_IDLE, EBA_PROG} eba_state_type;

endpackage

/* File: hdl/eba_ctrl.sv */
// eeprom byte access control: registers, write timing, stall and ready interrupt
`timescale 1ns/100ps
`default_nettype none

module eba_ctrl #(
  parameter int WRITE_RC_CYCLES = eba_pkg::WRITE_RC_CYCLES
) (
  // clock and resets
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        cold_nrst_i,
  // cpu i/o register access
  input  wire logic [7:0]  io_addr_i,
  input  wire logic        io_short_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  // cpu status and flash self-programming
  input  wire logic        glb_irq_en_i,
  input  wire logic        flash_selfprog_busy_i,
  output logic             cpu_stall_o,
  output logic             ready_irq_o,
  // calibrated rc oscillator tick, one cycle per rc period
  input  wire logic        rc_tick_i,
  // cell array side
  input  wire logic [7:0]  ee_rdata_i,
  output logic      [9:0]  ee_addr_o,
  output logic      [7:0]  ee_wdata_o,
  output logic      [1:0]  ee_mode_o,
  output logic             ee_prog_o,
  output logic             ee_busy_o
);

  // ****************************************************
  // state
  // ****************************************************
  eba_pkg::eba_state_type state_reg;
  logic [eba_pkg::RC_CNT_W-1:0] rc_cnt_reg;
  logic [9:0]  addr_reg;
  logic [7:0]  temp_reg;
  logic [7:0]  data_reg;
  logic [1:0]  mode_reg;
  logic        rie_reg;
  logic        mwe_reg;
  logic [2:0]  mwe_cnt_reg;
  logic [2:0]  stall_cnt_reg;
  logic [2:0]  stall_cnt_next;
  logic        prog_reg;
  logic [7:0]  rdata_reg;
  logic        stall_reg;
  logic        irq_reg;

  logic [7:0]  eff_addr;
  logic        wr_ctrl;
  logic        wr_data;
  logic        wr_lo;
  logic        wr_hi;
  logic        rd_lo;
  logic        busy;
  logic        start_write;
  logic        start_read;

  // ****************************************************
  // address decode
  // ****************************************************
  assign eff_addr = io_short_i ? 8'(io_addr_i + eba_pkg::IO_SHORT_DISP) : io_addr_i;
  assign wr_ctrl  = io_wr_i && (eff_addr == eba_pkg::CTRL_OFS);
  assign wr_data  = io_wr_i && (eff_addr == eba_pkg::DATA_OFS);
  assign wr_lo    = io_wr_i && (eff_addr == eba_pkg::ADDR_LO_OFS);
  assign wr_hi    = io_wr_i && (eff_addr == 8'(eba_pkg::ADDR_LO_OFS + eba_pkg::ADDR_HI_STEP));
  assign rd_lo    = io_rd_i && (eff_addr == eba_pkg::ADDR_LO_OFS);
  assign busy     = (state_reg == eba_pkg::EBA_PROG);

  // reserved mode and flash activity turn the strobe into a no-op
  // mode judged as written with the strobe, since that is what the array runs
  assign start_write = wr_ctrl && io_wdata_i[eba_pkg::CTRL_WSTB_BIT] && mwe_reg && !busy
                       && !flash_selfprog_busy_i
                       && (io_wdata_i[eba_pkg::CTRL_PM_MSB:eba_pkg::CTRL_PM_LSB] != eba_pkg::MODE_RESERVED);
  assign start_read  = wr_ctrl && io_wdata_i[eba_pkg::CTRL_RSTB_BIT] && !busy && !start_write;

  // ****************************************************
  // self-timed programming; only the power-on reset stops it
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!cold_nrst_i) begin
      state_reg  <= eba_pkg::EBA_IDLE;
      rc_cnt_reg <= '0;
    end else begin
      case (state_reg)
        eba_pkg::EBA_IDLE: begin
          rc_cnt_reg <= '0;
          if (start_write && nrst_i) begin
            state_reg <= eba_pkg::EBA_PROG;
          end
        end
        eba_pkg::EBA_PROG: begin
          if (rc_tick_i) begin
            if (rc_cnt_reg == eba_pkg::RC_CNT_W'(WRITE_RC_CYCLES - 1)) begin
              state_reg <= eba_pkg::EBA_IDLE;
            end else begin
              rc_cnt_reg <= rc_cnt_reg + 1'b1;
            end
          end
        end
        default: begin
          state_reg <= eba_pkg::EBA_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // address with high-byte staging
  // ****************************************************
  // address only clears on power-on; software must load it
  always_ff @(posedge clk_sys_i) begin
    if (!cold_nrst_i) begin
      addr_reg <= eba_pkg::ADDR_RST;
      temp_reg <= 8'h00;
    end else begin
      if (wr_hi) begin
        temp_reg <= io_wdata_i;
      end else if (rd_lo) begin
        temp_reg <= {6'h00, addr_reg[9:8]};
      end
      if (wr_lo && !busy) begin
        addr_reg <= {temp_reg[1:0], io_wdata_i};
      end
    end
  end

  // ****************************************************
  // data register
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      data_reg <= eba_pkg::DATA_RST;
    end else if (start_read) begin
      data_reg <= ee_rdata_i;
    end else if (wr_data && !busy) begin
      data_reg <= io_wdata_i;
    end
  end

  // ****************************************************
  // mode field
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!cold_nrst_i) begin
      mode_reg <= eba_pkg::MODE_RST;
    end else if (!nrst_i) begin
      if (!busy) begin
        mode_reg <= eba_pkg::MODE_RST;
      end
    end else if (wr_ctrl && !busy) begin
      mode_reg <= io_wdata_i[eba_pkg::CTRL_PM_MSB:eba_pkg::CTRL_PM_LSB];
    end
  end

  // ****************************************************
  // ready interrupt enable and timed master enable
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      rie_reg <= io_wdata_i[eba_pkg::CTRL_RIE_BIT];
    end
  end

  // window is short on purpose: an interrupt between arm and strobe lets it expire
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      mwe_reg     <= 1'b0;
      mwe_cnt_reg <= 3'h0;
    end else if (wr_ctrl && io_wdata_i[eba_pkg::CTRL_MWE_BIT] && !io_wdata_i[eba_pkg::CTRL_WSTB_BIT]) begin
      mwe_reg     <= 1'b1;
      mwe_cnt_reg <= eba_pkg::MWE_CYCLES;
    end else if (start_write) begin
      mwe_reg     <= 1'b0;
      mwe_cnt_reg <= 3'h0;
    end else if (mwe_reg) begin
      mwe_cnt_reg <= mwe_cnt_reg - 1'b1;
      if (mwe_cnt_reg == 3'h1) begin
        mwe_reg <= 1'b0;
      end
    end
  end

  // ****************************************************
  // cpu stall
  // ****************************************************
  always_comb begin
    stall_cnt_next = (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 1'b1 : 3'h0;
    if (start_write) begin
      stall_cnt_next = eba_pkg::WRITE_STALL_CYCLES;
    end else if (start_read) begin
      stall_cnt_next = eba_pkg::READ_STALL_CYCLES;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      stall_cnt_reg <= 3'h0;
      stall_reg     <= 1'b0;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
      stall_reg     <= (stall_cnt_next != 3'h0);
    end
  end

  // ****************************************************
  // array strobe, ready interrupt, read-back
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!cold_nrst_i) begin
      prog_reg <= 1'b0;
    end else begin
      prog_reg <= start_write && nrst_i;
    end
  end

  // level, not pulse: stays up as long as the array is idle and no flash self-programming runs
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= rie_reg && glb_irq_en_i && !busy && !start_write && !flash_selfprog_busy_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else if (io_rd_i) begin
      case (eff_addr)
        eba_pkg::CTRL_OFS:    rdata_reg <= {2'h0, mode_reg, rie_reg, mwe_reg, busy, 1'b0};
        eba_pkg::DATA_OFS:    rdata_reg <= data_reg;
        eba_pkg::ADDR_LO_OFS: rdata_reg <= addr_reg[7:0];
        8'(eba_pkg::ADDR_LO_OFS + eba_pkg::ADDR_HI_STEP): rdata_reg <= temp_reg;
        default:              rdata_reg <= 8'h00;
      endcase
    end
  end

  assign io_rdata_o  = rdata_reg;
  assign cpu_stall_o = stall_reg;
  assign ready_irq_o = irq_reg;
  assign ee_addr_o   = addr_reg;
  assign ee_wdata_o  = data_reg;
  assign ee_mode_o   = mode_reg;
  assign ee_prog_o   = prog_reg;
  assign ee_busy_o   = busy;

endmodule

`default_nettype wire

/* File: bench/eba_ctrl_assertions.sv */
// port-level assertions for the eeprom access control block
`timescale 1ns/100ps
`default_nettype none
module eba_ctrl_checker #(
  parameter int WRITE_RC_CYCLES = 8
) (
  // clock and resets
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       cold_nrst_i,
  // cpu side
  input wire logic [7:0] io_addr_i,
  input wire logic       io_short_i,
  input wire logic       io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic       flash_selfprog_busy_i,
  input wire logic       cpu_stall_o,
  input wire logic       ready_irq_o,
  // array side
  input wire logic [9:0] ee_addr_o,
  input wire logic [1:0] ee_mode_o,
  input wire logic       ee_prog_o,
  input wire logic       ee_busy_o
);
  logic [7:0] eff;
  logic       rd_go;
  logic       wstb;
  assign eff   = io_short_i ? io_addr_i + 8'h20 : io_addr_i;
  assign rd_go = io_wr_i && eff == 8'h3F && io_wdata_i[0] && !ee_busy_o;
  assign wstb  = io_wr_i && eff == 8'h3F && io_wdata_i[1];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i || !cold_nrst_i);
  a_prog_from_idle: assert property (ee_prog_o |-> ee_busy_o && !$past(ee_busy_o))
    else $error("start pulse without idle to busy step");
  a_write_stall_two: assert property (ee_prog_o |-> cpu_stall_o ##1 cpu_stall_o)
    else $error("write stall shorter than two cycles");
  a_read_stall_four: assert property (rd_go |=> cpu_stall_o [*4])
    else $error("read stall shorter than four cycles");
  a_flash_blocks_prog: assert property (flash_selfprog_busy_i |=> !ee_prog_o)
    else $error("write started during flash programming");
  a_irq_quiet_busy: assert property (ee_busy_o || flash_selfprog_busy_i |=> !ready_irq_o)
    else $error("ready interrupt while busy");
  a_busy_frozen: assert property (ee_busy_o && $past(ee_busy_o) |-> $stable(ee_addr_o) && $stable(ee_mode_o))
    else $error("address or mode changed while busy");
  a_mode_legal: assert property (ee_prog_o |-> ee_mode_o != 2'h3)
    else $error("reserved mode started a write");
  a_prog_needs_wr: assert property (ee_prog_o |-> $past(wstb))
    else $error("write started without a strobe");
  a_prog_one_pulse: assert property (ee_prog_o |=> !ee_prog_o)
    else $error("start pulse longer than one cycle");
endmodule
bind eba_ctrl eba_ctrl_checker #(.WRITE_RC_CYCLES(WRITE_RC_CYCLES)) chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cold_nrst_i(cold_nrst_i), .io_addr_i(io_addr_i),
  .io_short_i(io_short_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
  .flash_selfprog_busy_i(flash_selfprog_busy_i), .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
  .ee_addr_o(ee_addr_o), .ee_mode_o(ee_mode_o), .ee_prog_o(ee_prog_o), .ee_busy_o(ee_busy_o));
`default_nettype wire

/* File: bench/eba_array_model.sv */
// behavioural cell array and rc oscillator tick
`timescale 1ns/100ps
`default_nettype none
module eba_array_model (
  // clock and rc tick
  input  wire logic       clk_sys_i,
  output logic            rc_tick_o,
  // array port
  input  wire logic [9:0] ee_addr_i,
  input  wire logic [7:0] ee_wdata_i,
  input  wire logic [1:0] ee_mode_i,
  input  wire logic       ee_prog_i,
  output logic      [7:0] ee_rdata_o
);
  logic [7:0] mem [1024];
  logic [1:0] div_reg = 2'h0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // tick every fourth cycle so the write time is visible
  // plain always: mem is also preset by the initial block
  always @(posedge clk_sys_i) begin
    div_reg <= div_reg + 2'h1;
    if (ee_prog_i) begin
      case (ee_mode_i)
        2'h0: mem[ee_addr_i] <= ee_wdata_i;
        2'h1: mem[ee_addr_i] <= 8'hFF;
        2'h2: mem[ee_addr_i] <= mem[ee_addr_i] & ee_wdata_i;
        default: ;
      endcase
    end
  end
  assign rc_tick_o  = div_reg == 2'h3;
  assign ee_rdata_o = mem[ee_addr_i];
endmodule
`default_nettype wire

/* File: bench/tb_eba_ctrl.sv */
// self-checking bench for the eeprom access control block
`timescale 1ns/100ps
`default_nettype none
module tb_eba_ctrl;
  localparam int WRC = 8;
  logic        clk_sys_i, nrst_i, cold_nrst_i, io_short_i, io_wr_i, io_rd_i, glb_irq_en_i;
  logic        flash_selfprog_busy_i, cpu_stall_o, ready_irq_o, rc_tick_i, ee_prog_o, ee_busy_o;
  logic [7:0]  io_addr_i, io_wdata_i, io_rdata_o, ee_rdata_i, ee_wdata_o, v, d;
  logic [9:0]  ee_addr_o, a;
  logic [1:0]  ee_mode_o;
  logic [15:0] seed = 16'hB20C;
  logic [7:0]  shd [1024];
  int          error_cnt, compares, cyc, n;
  eba_ctrl #(.WRITE_RC_CYCLES(WRC)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cold_nrst_i(cold_nrst_i),
    .io_addr_i(io_addr_i), .io_short_i(io_short_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .glb_irq_en_i(glb_irq_en_i),
    .flash_selfprog_busy_i(flash_selfprog_busy_i), .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
    .rc_tick_i(rc_tick_i), .ee_rdata_i(ee_rdata_i), .ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o),
    .ee_mode_o(ee_mode_o), .ee_prog_o(ee_prog_o), .ee_busy_o(ee_busy_o));
  eba_array_model mdl (.clk_sys_i(clk_sys_i), .rc_tick_o(rc_tick_i), .ee_addr_i(ee_addr_o),
    .ee_wdata_i(ee_wdata_o), .ee_mode_i(ee_mode_o), .ee_prog_i(ee_prog_o), .ee_rdata_o(ee_rdata_i));
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  function automatic logic [7:0] exp_byte(logic [7:0] o, logic [7:0] w, logic [1:0] m);
    return m == 2'h0 ? w : m == 2'h1 ? 8'hFF : m == 2'h2 ? o & w : o;
  endfunction
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // short form picked at random so both address views get used
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    logic [15:0] r;
    r = rnd();
    io_short_i = r[0] && ad >= 8'h20;
    io_addr_i  = io_short_i ? ad - 8'h20 : ad;
    io_wdata_i = dt;
    io_wr_i    = w;
    io_rd_i    = !w;
    @(posedge clk_sys_i);
    #1;
    v = io_rdata_o;
  endtask
  // strobes drop here so that an edge passes between two transfers
  task automatic idle();
    {io_wr_i, io_rd_i} = 2'b00;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_idle();
    n = 0;
    do begin
      acc(1'b0, 8'h3F, 8'h00);
      n++;
    end while (v[1] && n < 100);
  endtask
  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ****
  // timeout
  // ****
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    {nrst_i, cold_nrst_i, io_wr_i, io_rd_i, io_short_i, glb_irq_en_i, flash_selfprog_busy_i} = '0;
    {io_addr_i, io_wdata_i} = '0;
    foreach (shd[i]) shd[i] = 8'hFF;
    repeat (3) @(posedge clk_sys_i);
    #1 {nrst_i, cold_nrst_i} = 2'b11;
    acc(1'b0, 8'h3F, 8'h00);
    chk(v, 8'h00);
    acc(1'b0, 8'h50, 8'h00);
    chk(v, 8'h00);
    for (int m = 0; m < 4; m++) begin
      a = 10'(rnd());
      d = 8'(rnd());
      acc(1'b1, 8'h42, {6'h00, a[9:8]});
      acc(1'b1, 8'h41, a[7:0]);
      acc(1'b1, 8'h40, d);
      acc(1'b0, 8'h41, d);
      chk(v, a[7:0]);
      acc(1'b0, 8'h42, d);
      chk(v, a[9:8]);
      acc(1'b1, 8'h3F, {2'h0, 2'(m), 4'h4});
      acc(1'b1, 8'h3F, {2'h0, 2'(m), 4'h2});
      chk(ee_prog_o, m != 3);
      if (m != 3) begin
        chk({ee_mode_o, ee_wdata_o}, {2'(m), d});
        chk(ee_addr_o, a);
        chk(cpu_stall_o, 1'b1);
        acc(1'b1, 8'h3F, 8'h30);
        acc(1'b1, 8'h41, ~a[7:0]);
        acc(1'b0, 8'h3F, d);
        chk(v, {2'h0, 2'(m), 4'h2});
        chk(ee_addr_o, a);
        wait_idle();
        // rc tick every fourth cycle, polls start four edges after the start
        chk(n >= 4 * WRC - 5 && n <= 4 * WRC - 2, 1'b1);
      end
      shd[a] = exp_byte(shd[a], d, 2'(m));
      acc(1'b1, 8'h3F, 8'h01);
      chk(cpu_stall_o, 1'b1);
      acc(1'b0, 8'h40, d);
      chk(v, shd[a]);
      $display("mode %0d test done", m);
    end
    // master enable seen one and four edges after arming, gone at five
    acc(1'b1, 8'h3F, 8'h04);
    acc(1'b0, 8'h3F, d);
    chk(v[2], 1'b1);
    idle();
    idle();
    acc(1'b0, 8'h3F, d);
    chk(v[2], 1'b1);
    acc(1'b1, 8'h3F, 8'h02);
    chk(ee_prog_o, 1'b0);
    flash_selfprog_busy_i = 1'b1;
    acc(1'b1, 8'h3F, 8'h04);
    acc(1'b1, 8'h3F, 8'h02);
    chk(ee_prog_o, 1'b0);
    flash_selfprog_busy_i = 1'b0;
    glb_irq_en_i = 1'b1;
    acc(1'b1, 8'h3F, 8'h08);
    idle();
    chk(ready_irq_o, 1'b1);
    flash_selfprog_busy_i = 1'b1;
    idle();
    chk(ready_irq_o, 1'b0);
    flash_selfprog_busy_i = 1'b0;
    $display("guard test done");
    glb_irq_en_i = 1'b0;
    d = 8'(rnd());
    acc(1'b1, 8'h40, d);
    acc(1'b1, 8'h3F, 8'h2C);
    acc(1'b1, 8'h3F, 8'h2A);
    shd[a] = exp_byte(shd[a], d, 2'h2);
    nrst_i = 1'b0;
    idle();
    idle();
    nrst_i = 1'b1;
    acc(1'b0, 8'h3F, d);
    chk(v, 8'h22);
    wait_idle();
    acc(1'b1, 8'h3F, 8'h01);
    acc(1'b0, 8'h40, d);
    chk(v, shd[a]);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
